// ### logic/mac_pkg.sv
//=============================================================
// Overview of operation
// - first input port data is two's complement when its sign control is high
// - second input port data is two's complement when its sign control is high
// - integer rounding control high rounds the result, low leaves it alone
// - fraction rounding control high rounds the result, low leaves it alone
// - negate control high complements the product before the adder
// - sum op 00 gives product, 01 product plus acc, 10 product minus acc
// - sum op 11 gives product; low source enables force operand one
// - shifter 00 passes data, 01 shifts left one filling zero
// - shifter 10 swaps temp halves, 11 shifts right 32 with sign fill
// - bypass 00 skips all, 01 product only, 10 product and result, 11 none
// - test pins 00 force outputs low, 01 force outputs high
// - test pins 10 float outputs, 11 normal and default
// - two 32 bit input ports, optionally held in operand registers
// - operand muxes pick raw port, operand register or temp register
// - temp register loads only from shifter, fed by inputs or sum
// - 67 bit sum goes to result port or through shifter to acc
// - 64 bit input word reaches shifter zero or sign extended
// - low 64 shifter bits latch into temp, then feed operand muxes
// - swap option exchanges temp halves ahead of operand muxes
// - three bit bus drives top three bits of the 67 bit sum
// - shifter 10 sends temp high half to second mux, else first
// - fraction rounding adds one at bit 30, integer rounding at 31
package mac_pkg;
    localparam int            DW         = 32;
    localparam int            SW         = 67;
    localparam int            TW         = 64;
    localparam int            IW         = 7;
    // ==========================================================
    // instruction register fields
    localparam int            I_SGNA     = 0;
    localparam int            I_SGNB     = 1;
    localparam int            I_RNDI     = 2;
    localparam int            I_RNDF     = 3;
    localparam int            I_OP0      = 4;
    localparam int            I_OP1      = 5;
    localparam int            I_NEG      = 6;
    // ==========================================================
    // bypass vector bits
    localparam int            BYP_B      = 0;
    localparam int            BYP_A      = 1;
    localparam int            BYP_I      = 2;
    localparam int            BYP_Y      = 3;
    localparam int            BYP_P      = 4;
    localparam logic [4:0]    BYP_ALL    = 5'h1F;
    localparam logic [4:0]    BYP_PROD   = 5'h10;
    localparam logic [4:0]    BYP_PRES   = 5'h18;
    localparam logic [4:0]    BYP_NONE   = 5'h00;
    // ==========================================================
    // two bit codes
    localparam logic [1:0]    OP_PROD    = 2'h0;
    localparam logic [1:0]    OP_ADD     = 2'h1;
    localparam logic [1:0]    OP_SUB     = 2'h2;
    localparam logic [1:0]    OP_DIRECT  = 2'h3;
    localparam logic [1:0]    SH_PASS    = 2'h0;
    localparam logic [1:0]    SH_LEFT    = 2'h1;
    localparam logic [1:0]    SH_SWAP    = 2'h2;
    localparam logic [1:0]    SH_RIGHT   = 2'h3;
    localparam logic [1:0]    TP_LOW     = 2'h0;
    localparam logic [1:0]    TP_HIGH    = 2'h1;
    localparam logic [1:0]    TP_FLOAT   = 2'h2;
    localparam logic [1:0]    TP_NORMAL  = 2'h3;
    localparam int            RND_INT_BIT  = 31;
    localparam int            RND_FRAC_BIT = 30;
    localparam int            SHIFT_WORD   = 32;
    // ==========================================================
    // apb register map
    localparam logic [7:0]    OFS_CTRL   = 8'h00;
    localparam logic [7:0]    OFS_ACC_LO = 8'h04;
    localparam logic [7:0]    OFS_ACC_HI = 8'h08;
    localparam logic [7:0]    OFS_RESULT = 8'h0C;
    localparam int            C_EXT      = 0;
    localparam int            C_SGNEXT   = 1;
    localparam int            C_TEMP     = 2;
    localparam int            C_UPPER    = 3;
    localparam logic [3:0]    CTRL_RST   = 4'h0;
    localparam logic [1:0]    TP_RST     = 2'h3;
endpackage

// ### logic/mac_pin_sync.sv
`timescale 1ns/100ps
module mac_pin_sync #(
    parameter int          W         = 2,
    parameter logic [1:0]  RST_VALUE = 2'h3
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [W-1:0]  pin,
    output logic      [W-1:0]  stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } mac_sync_t;

    mac_sync_t cur;
    mac_sync_t next_cur;

    // ==========================================================
    // three stage chain; first stage only feeds the second
    always_comb begin
        next_cur    = cur;
        next_cur.s1 = pin;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        if (cur.s2 == cur.s3) begin
            next_cur.val = cur.s3;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur <= {4{RST_VALUE[W-1:0]}};
        end else begin
            cur <= next_cur;
        end
    end

    assign stable = cur.val;
endmodule

// ### logic/mac_datapath.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
module mac_datapath (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [mac_pkg::DW-1:0]  first_input_port,
    input  wire logic [mac_pkg::DW-1:0]  second_input_port,
    input  wire logic                    first_input_signed,
    input  wire logic                    second_input_signed,
    input  wire logic                    round_integer,
    input  wire logic                    round_fraction,
    input  wire logic                    negate_product,
    input  wire logic                    sum_op_select_lo,
    input  wire logic                    sum_op_select_hi,
    input  wire logic                    first_operand_source_n,
    input  wire logic                    second_operand_source_n,
    input  wire logic                    shifter_ctl_lo,
    input  wire logic                    shifter_ctl_hi,
    input  wire logic                    bypass_sel_lo,
    input  wire logic                    bypass_sel_hi,
    input  wire logic                    test_force_lo,
    input  wire logic                    test_force_hi,
    input  wire logic                    load_first_n,
    input  wire logic                    load_second_n,
    input  wire logic                    load_instr_n,
    input  wire logic                    load_product_n,
    input  wire logic                    load_result_n,
    input  wire logic                    write_low_n,
    input  wire logic                    write_high_n,
    output logic      [mac_pkg::DW-1:0]  result_out,
    output logic                         result_oe,
    output logic                         product_top_bit0,
    output logic                         product_top_bit1,
    output logic                         product_top_bit2,
    output logic                         product_top_oe,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr
);
    import mac_pkg::*;

    typedef struct packed {
        logic [DW-1:0] reg_a;
        logic [DW-1:0] reg_b;
        logic [IW-1:0] instr;
        logic [SW-1:0] prod;
        logic [SW-1:0] res;
        logic [TW-1:0] temp;
        logic [TW-1:0] acc;
        logic [3:0]    ctrl;
        logic [31:0]   rdata;
    } mac_state_t;

    mac_state_t    cur;
    mac_state_t    next_cur;
    logic [1:0]    tp;
    logic [4:0]    byp;
    logic [IW-1:0] instr;
    logic [1:0]    op;
    logic [1:0]    sft;
    logic [DW-1:0] a_val;
    logic [DW-1:0] b_val;
    logic [DW-1:0] swap_r;
    logic [DW-1:0] swap_s;
    logic [DW-1:0] op_r;
    logic [DW-1:0] op_s;
    logic          r_sgn;
    logic          s_sgn;
    logic [65:0]   mult;
    logic [SW-1:0] prod_c;
    logic [SW-1:0] prod_u;
    logic [SW-1:0] acc_ext;
    logic [SW-1:0] rnd;
    logic [SW-1:0] sum;
    logic [SW-1:0] res_u;
    logic [SW-1:0] d_in;
    logic [SW-1:0] shift_out;
    logic [DW-1:0] y_norm;
    logic          unmapped;

    // ==========================================================
    // bypass decode
    function automatic logic [4:0] mac_bypass_decode(input logic [1:0] sel);
        logic [4:0] v;
        v = BYP_NONE;
        case (sel)
            2'h0: v = BYP_ALL;
            2'h1: v = BYP_PROD;
            2'h2: v = BYP_PRES;
            default: v = BYP_NONE;
        endcase
        return v;
    endfunction

    function automatic logic mac_is_mapped(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_ACC_LO) || (a == OFS_ACC_HI) ||
               (a == OFS_RESULT);
    endfunction

    // test pins arrive from a tester, not from the controller clock
    mac_pin_sync #(
        .W         (2),
        .RST_VALUE (TP_RST)
    ) u_tp_sync (
        .clock  (clock),
        .rst    (rst),
        .pin    ({test_force_hi, test_force_lo}),
        .stable (tp)
    );

    // ==========================================================
    // datapath and next state
    always_comb begin
        next_cur = cur;
        sft      = {shifter_ctl_hi, shifter_ctl_lo};
        byp      = mac_bypass_decode({bypass_sel_hi, bypass_sel_lo});
        instr    = byp[BYP_I] ? {negate_product, sum_op_select_hi, sum_op_select_lo,
                                 round_fraction, round_integer, second_input_signed,
                                 first_input_signed} : cur.instr;
        op       = {instr[I_OP1], instr[I_OP0]};
        a_val    = byp[BYP_A] ? first_input_port : cur.reg_a;
        b_val    = byp[BYP_B] ? second_input_port : cur.reg_b;
        if (sft == SH_SWAP) begin
            swap_r = cur.temp[DW-1:0];
            swap_s = cur.temp[TW-1:DW];
        end else begin
            swap_r = cur.temp[TW-1:DW];
            swap_s = cur.temp[DW-1:0];
        end

        op_r  = first_operand_source_n ? a_val : swap_r;
        op_s  = second_operand_source_n ? b_val : swap_s;
        r_sgn = instr[I_SGNA];
        s_sgn = instr[I_SGNB];

        // direct op forces one on a disabled source
        if (op == OP_DIRECT && !first_operand_source_n) begin
            op_r  = 32'h00000001;
            r_sgn = 1'b0;
        end
        if (op == OP_DIRECT && !second_operand_source_n) begin
            op_s  = 32'h00000001;
            s_sgn = 1'b0;
        end
        mult = 66'($signed({r_sgn & op_r[DW-1], op_r}) *
                   $signed({s_sgn & op_s[DW-1], op_s}));

        prod_c  = instr[I_NEG] ? SW'(-{mult[65], mult}) : {mult[65], mult};
        prod_u  = byp[BYP_P] ? prod_c : cur.prod;
        acc_ext = {{(SW-TW){cur.acc[TW-1]}}, cur.acc};

        rnd = '0;
        if (instr[I_RNDI]) begin
            rnd[RND_INT_BIT] = 1'b1;
        end
        if (instr[I_RNDF]) begin
            rnd = SW'(rnd + (SW'(1) << RND_FRAC_BIT));
        end

        case (op)
            OP_ADD:  sum = SW'(prod_u + acc_ext + rnd);
            OP_SUB:  sum = SW'(prod_u - acc_ext + rnd);
            default: sum = SW'(prod_u + rnd);
        endcase
        res_u = byp[BYP_Y] ? sum : cur.res;

        // external word with zero or sign fill
        d_in = cur.ctrl[C_EXT]
             ? {{(SW-TW){cur.ctrl[C_SGNEXT] & first_input_port[DW-1]}},
                first_input_port, second_input_port}
             : sum;

        // swap passes, right shift sign fills
        case (sft)
            SH_LEFT:  shift_out = {d_in[SW-2:0], 1'b0};
            SH_RIGHT: shift_out = SW'($signed(d_in) >>> SHIFT_WORD);
            default:  shift_out = d_in;
        endcase

        if (!load_first_n) begin
            next_cur.reg_a = first_input_port;
        end
        if (!load_second_n) begin
            next_cur.reg_b = second_input_port;
        end
        if (!load_instr_n) begin
            next_cur.instr = {negate_product, sum_op_select_hi, sum_op_select_lo,
                              round_fraction, round_integer, second_input_signed,
                              first_input_signed};
        end
        if (!load_product_n) begin
            next_cur.prod = prod_c;
        end
        if (!load_result_n) begin
            next_cur.res = sum;
        end

        // temp takes low 64 shifter bits
        // sum routed to accumulator through shifter
        if (cur.ctrl[C_TEMP]) begin
            if (!write_low_n) begin
                next_cur.temp[DW-1:0] = shift_out[DW-1:0];
            end
            if (!write_high_n) begin
                next_cur.temp[TW-1:DW] = shift_out[TW-1:DW];
            end
        end else begin
            if (!write_low_n) begin
                next_cur.acc[DW-1:0] = shift_out[DW-1:0];
            end
            if (!write_high_n) begin
                next_cur.acc[TW-1:DW] = shift_out[TW-1:DW];
            end
        end

        // apb: read data latched in setup, so the access phase needs no wait
        unmapped = !mac_is_mapped(paddr);
        if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_CTRL:   next_cur.rdata = {28'h0000000, cur.ctrl};
                OFS_ACC_LO: next_cur.rdata = cur.acc[DW-1:0];
                OFS_ACC_HI: next_cur.rdata = cur.acc[TW-1:DW];
                OFS_RESULT: next_cur.rdata = {29'h00000000, res_u[SW-1:TW]};
                default:    next_cur.rdata = 32'h00000000;
            endcase
        end
        if (psel && penable && pwrite && paddr == OFS_CTRL) begin
            next_cur.ctrl = pwdata[3:0];
        end

        y_norm = cur.ctrl[C_UPPER] ? res_u[TW-1:DW] : res_u[DW-1:0];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur      <= '0;
            cur.ctrl <= CTRL_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // outputs with test forcing
    always_comb begin
        case (tp)
            TP_LOW: begin
                result_out = '0;
                {product_top_bit2, product_top_bit1, product_top_bit0} = 3'h0;
                result_oe  = 1'b1;
            end
            TP_HIGH: begin
                result_out = '1;
                {product_top_bit2, product_top_bit1, product_top_bit0} = 3'h7;
                result_oe  = 1'b1;
            end
            TP_FLOAT: begin
                result_out = '0;
                {product_top_bit2, product_top_bit1, product_top_bit0} = 3'h0;
                result_oe  = 1'b0;
            end
            default: begin
                result_out = y_norm;
                {product_top_bit2, product_top_bit1, product_top_bit0} = res_u[SW-1:TW];
                result_oe  = 1'b1;
            end
        endcase
        product_top_oe = result_oe;
    end

    assign prdata  = cur.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & unmapped;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence res_load_s;
        !load_result_n && byp == BYP_NONE;
    endsequence

    sequence tp_low_s;
        tp == TP_LOW;
    endsequence

    result_reg_load_a: assert property (res_load_s |=> cur.res == $past(sum))
        else $error("result register missed its load");

    flowthru_result_a: assert property (byp == BYP_ALL |-> res_u == sum)
        else $error("flowthrough result not passed");

    force_low_a: assert property (tp_low_s |-> result_out == '0 && result_oe)
        else $error("test low not forced");

    force_float_a: assert property (tp == TP_FLOAT |-> !result_oe && !product_top_oe)
        else $error("test float still driving");

    shift_left_a: assert property (sft == SH_LEFT |-> shift_out == {d_in[SW-2:0], 1'b0})
        else $error("left shift wrong");

    shift_right_a: assert property (sft == SH_RIGHT |->
                                    shift_out[SW-1:SW-32] == {32{d_in[SW-1]}})
        else $error("right shift fill wrong");

    temp_low_load_a: assert property (cur.ctrl[C_TEMP] && !write_low_n |=>
                                      cur.temp[DW-1:0] == $past(shift_out[DW-1:0]))
        else $error("temp low half not loaded");

    swap_route_a: assert property (sft == SH_SWAP && !first_operand_source_n &&
                                   op != OP_DIRECT |-> op_r == cur.temp[DW-1:0])
        else $error("swap routing wrong");

    force_one_a: assert property (op == OP_DIRECT && !first_operand_source_n &&
                                  !second_operand_source_n && !instr[I_RNDI] &&
                                  !instr[I_RNDF] && byp[BYP_P] |->
                                  sum == (instr[I_NEG] ? '1 : SW'(1)))
        else $error("direct op constant one wrong");

    ext_bits_a: assert property (tp == TP_NORMAL |->
                                 product_top_bit2 == res_u[SW-1])
        else $error("extended bit wrong");
endmodule

// ### tb/mac_ctrl_model.sv
`timescale 1ns/100ps
// ==========================================================
// sequencer model: owns the operand buses and instruction pins
module mac_ctrl_model (
    input  wire logic                    clock,
    output logic      [mac_pkg::DW-1:0]  opa,
    output logic      [mac_pkg::DW-1:0]  opb,
    output logic      [mac_pkg::IW-1:0]  ins,
    output logic      [5:0]              route
);
    import mac_pkg::*;
    // route: [5:4] bypass, [3:2] shifter, [1] second source_n, [0] first source_n
    initial begin
        opa = 32'h0;
        opb = 32'h0;
        ins = 7'h0;
        route = 6'h03;
    end
    // operand pair
    // all pins move together after an edge, so a register never sees a half-changed word
    task automatic issue(input logic [DW-1:0] a, input logic [DW-1:0] b,
                         input logic [IW-1:0] i);
        @(posedge clock);
        opa <= a;
        opb <= b;
        ins <= i;
    endtask
    task automatic steer(input logic [5:0] r);
        @(posedge clock);
        route <= r;
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import mac_pkg::*;
    // ==========================================================
    // signals
    logic                clock;
    logic                rst;
    logic  [1:0]         tp;
    logic  [4:0]         load_n;
    logic  [1:0]         wr_n;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic  [7:0]         paddr;
    logic  [31:0]        pwdata;
    logic  [31:0]        prdata;
    logic                pready;
    logic                pslverr;
    logic  [31:0]        result_out;
    logic                result_oe;
    logic                product_top_oe;
    logic  [2:0]         tops;
    logic  [DW-1:0]      opa;
    logic  [DW-1:0]      opb;
    logic  [IW-1:0]      ins;
    logic  [5:0]         route;
    logic                upper;
    int                  n_errors;
    int                  compares;
    int                  cycles;
    wire   [34:0]        seen = {tops, result_out};
    // ==========================================================
    // instances
    mac_ctrl_model i_ctrl (.clock(clock), .opa(opa), .opb(opb), .ins(ins), .route(route));
    mac_datapath i_dut (
        .clock(clock), .rst(rst),
        .first_input_port(opa), .second_input_port(opb),
        .first_input_signed(ins[I_SGNA]), .second_input_signed(ins[I_SGNB]),
        .round_integer(ins[I_RNDI]), .round_fraction(ins[I_RNDF]),
        .negate_product(ins[I_NEG]),
        .sum_op_select_lo(ins[I_OP0]), .sum_op_select_hi(ins[I_OP1]),
        .first_operand_source_n(route[0]), .second_operand_source_n(route[1]),
        .shifter_ctl_lo(route[2]), .shifter_ctl_hi(route[3]),
        .bypass_sel_lo(route[4]), .bypass_sel_hi(route[5]),
        .test_force_lo(tp[0]), .test_force_hi(tp[1]),
        .load_first_n(load_n[0]), .load_second_n(load_n[1]), .load_instr_n(load_n[2]),
        .load_product_n(load_n[3]), .load_result_n(load_n[4]),
        .write_low_n(wr_n[0]), .write_high_n(wr_n[1]),
        .result_out(result_out), .result_oe(result_oe),
        .product_top_bit0(tops[0]), .product_top_bit1(tops[1]), .product_top_bit2(tops[2]),
        .product_top_oe(product_top_oe),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ==========================================================
    // reference and helpers
    function automatic logic [66:0] exp_sum(input logic [31:0] a, input logic [31:0] b,
                                            input logic [6:0] i, input logic [63:0] acc);
        logic [66:0] x;
        logic [66:0] y;
        logic [66:0] s;
        x = i[0] ? {{35{a[31]}}, a} : {35'h0, a};
        y = i[1] ? {{35{b[31]}}, b} : {35'h0, b};
        s = x * y;
        if (i[6]) s = -s;
        s = s + (67'(i[2]) << 31) + (67'(i[3]) << 30);
        if (i[5:4] == 2'h1) s = s + {{3{acc[63]}}, acc};
        if (i[5:4] == 2'h2) s = s - {{3{acc[63]}}, acc};
        return s;
    endfunction
    function automatic logic [34:0] half(input logic [66:0] s);
        return {s[66:64], upper ? s[63:32] : s[31:0]};
    endfunction
    task automatic close_out();
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [66:0] got, input logic [66:0] want);
        compares++;
        if (got !== want) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic look(input logic [66:0] s);
        @(negedge clock);
        chk(67'(seen), 67'(half(s)));
    endtask
    // ==========================================================
    // apb master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(67'({e, q}), 67'({err, x}));
    endtask
    // shifter word lands in acc or temp as CTRL says
    task automatic put(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b,
                       input logic [1:0] sh);
        wr(OFS_CTRL, c);
        i_ctrl.steer({2'h0, sh, 2'h3});
        i_ctrl.issue(a, b, 7'h0);
        @(posedge clock);
        wr_n <= 2'h0;
        @(posedge clock);
        wr_n <= 2'h3;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        rd(OFS_CTRL, 32'h0, 1'b0);
        rd(OFS_ACC_HI, 32'h0, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
    endtask
    task automatic t_signs();
        for (int u = 0; u < 2; u++) begin
            wr(OFS_CTRL, 32'(u * 8));
            upper = u[0];
            for (int k = 0; k < 4; k++) begin
                i_ctrl.issue(32'hFFFF_FFFE, 32'h8000_0003, 7'(k));
                look(exp_sum(32'hFFFF_FFFE, 32'h8000_0003, 7'(k), 64'h0));
            end
        end
        wr(OFS_CTRL, 32'h0);
        upper = 1'b0;
    endtask
    task automatic t_round();
        logic [6:0] i;
        logic [66:0] s;
        for (int k = 0; k < 8; k++) begin
            i = {k[2], 2'h0, k[1], k[0], 2'h3};
            s = exp_sum(32'h1234_5678, 32'hFEDC_BA98, i, 64'h0);
            i_ctrl.issue(32'h1234_5678, 32'hFEDC_BA98, i);
            look(s);
            rd(OFS_RESULT, 32'(s[66:64]), 1'b0);
        end
    endtask
    task automatic t_ops();
        logic [63:0] acc;
        acc = 64'h0000_0002_0000_0010;
        put(32'h1, 32'h2, 32'h10, SH_PASS);
        rd(OFS_ACC_LO, 32'h10, 1'b0);
        rd(OFS_ACC_HI, 32'h2, 1'b0);
        for (int k = 0; k < 3; k++) begin
            i_ctrl.issue(32'hFFFF_FFF0, 32'h0000_0300, {1'b0, 2'(k), 4'h3});
            look(exp_sum(32'hFFFF_FFF0, 32'h300, {1'b0, 2'(k), 4'h3}, acc));
        end
        for (int j = 0; j < 4; j++) begin
            i_ctrl.steer({4'h0, 2'(j)});
            i_ctrl.issue(32'h0001_2345, 32'hFFFF_FFF0, 7'h30);
            look(exp_sum(j[0] ? 32'h12345 : 32'h1, j[1] ? 32'hFFFF_FFF0 : 32'h1,
                         7'h30, acc));
        end
    endtask
    task automatic t_shift();
        logic [63:0] v;
        for (int k = 0; k < 4; k++) begin
            put(32'h3, 32'h8000_0001, 32'hC000_0002, 2'(k));
            case (k)
                0, 2: v = 64'h8000_0001_C000_0002;
                1: v = 64'h0000_0003_8000_0004;
                default: v = 64'hFFFF_FFFF_8000_0001;
            endcase
            rd(OFS_ACC_LO, v[31:0], 1'b0);
            rd(OFS_ACC_HI, v[63:32], 1'b0);
        end
    endtask
    task automatic t_temp();
        logic [5:0] r [4] = '{6'h02, 6'h0A, 6'h09, 6'h01};
        logic [31:0] m [4] = '{32'h3, 32'h5, 32'h3, 32'h5};
        put(32'h5, 32'h3, 32'h5, SH_PASS);
        for (int k = 0; k < 4; k++) begin
            i_ctrl.steer(r[k]);
            i_ctrl.issue(32'hB, 32'h7, 7'h0);
            look(exp_sum(m[k], k < 2 ? 32'h7 : 32'hB, 7'h0, 64'h0));
        end
    endtask
    task automatic t_bypass();
        logic [66:0] o;
        logic [66:0] n;
        int          lat;
        o = exp_sum(32'h11, 32'h22, 7'h0, 64'h0);
        n = exp_sum(32'h33, 32'h22, 7'h0, 64'h0);
        for (int k = 0; k < 4; k++) begin
            lat = (k == 0) ? 0 : (k == 1) ? 2 : (k == 2) ? 1 : 3;
            i_ctrl.steer({2'(k), 4'h3});
            i_ctrl.issue(32'h11, 32'h22, 7'h0);
            repeat (4) @(posedge clock);
            i_ctrl.issue(32'h33, 32'h22, 7'h0);
            for (int c = 0; c < 4; c++) begin
                @(negedge clock);
                chk(67'(seen), 67'(half(c < lat ? o : n)));
            end
        end
        // a closed result register must hold through later edges
        @(posedge clock) load_n <= 5'h10;
        i_ctrl.issue(32'h44, 32'h22, 7'h0);
        repeat (4) @(posedge clock);
        look(n);
        @(posedge clock) load_n <= 5'h00;
        i_ctrl.steer(6'h03);
    endtask
    task automatic t_test();
        logic [36:0] e;
        i_ctrl.issue(32'h5, 32'h6, 7'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock) tp <= 2'(k);
            repeat (5) @(posedge clock);
            @(negedge clock);
            e = (k == 0) ? 37'h18_0000_0000 : (k == 1) ? {37{1'b1}} : {2'h3, 35'h1E};
            if (k == 2) chk(67'({result_oe, product_top_oe}), 67'h0);
            else chk(67'({result_oe, product_top_oe, seen}), 67'(e));
        end
    endtask
    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        {rst, tp, load_n, wr_n} = {1'b1, 2'h3, 5'h00, 2'h3};
        {psel, penable, pwrite, paddr, pwdata} = {3'h0, 8'h0, 32'h0};
        {upper, n_errors, compares, cycles} = {1'b0, 32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_signs();
        t_round();
        t_ops();
        t_shift();
        t_temp();
        t_bypass();
        t_test();
        close_out();
    end
endmodule
